// ===== cbl_chan_decode.sv
// Purpose: Decode one channel setting byte into routing flags
// Assumes: Purely combinational; the caller registers the results
// Notes:   Prohibited gain code is kept as written and only flagged
`timescale 1ns/1ps
module cbl_chan_decode
	import cbl_pkg::*;
(
	input  cbl_chan_cfg_t cfg,
	input  wire logic     bias_measure_enable,
	output logic          gain_illegal,
	output logic          measure_route,
	output logic          drive_from_pos,
	output logic          drive_from_neg
);

	assign gain_illegal = (cfg.amp_gain_sel == GAIN_BAD);

	assign measure_route = bias_measure_enable
		&& (cfg.input_select == SEL_BIAS_MEASURE_ENABLE);

	assign drive_from_pos = (cfg.input_select == SEL_DRIVE_POS);
	assign drive_from_neg = (cfg.input_select == SEL_DRIVE_NEG);

endmodule

// ===== cbl_host_model.sv
// Purpose: APB master standing in for the host software
// Assumes: One transfer at a time; pready is awaited under a bounded count
// Notes:   Signals start cleared by a blocking assignment at time zero, then change by NBA just after a rising edge
`timescale 1ns/1ps
module cbl_host_model
	import cbl_pkg::*;
(
	input  wire logic          clk,
	input  wire logic   [31:0] prdata,
	input  wire logic          pready,
	input  wire logic          pslverr,
	output cbl_apb_req_t       apb_req
);
	initial begin
		apb_req = '0;
	end

	task automatic xfer(
		input  logic        wr,
		input  logic [7:0]  addr,
		input  logic [7:0]  data,
		input  logic [3:0]  strb,
		output logic [31:0] rdata,
		output logic        err,
		output logic        hang
	);
		int n;
		@(posedge clk);
		apb_req <= '{1'b1, 1'b0, wr, addr, {24'h0, data}, strb};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		n = 0;
		// Request held until pready is seen at an edge
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 32);
		hang = (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		apb_req <= '0;
	endtask
endmodule

// ===== cbl_mask_reg.sv
// Purpose: One byte-wide per-channel enable mask
// Assumes: Write strobe is a single-cycle pulse from the bus slave
// Notes:   Bits for absent channels are never stored and read as zero
`timescale 1ns/1ps
module cbl_mask_reg
	import cbl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic [7:0] valid_mask,
	output logic      [7:0] value
);

	wire logic [7:0] next_value = wr_data & valid_mask;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			value <= MASK_RESET;
		end else if (wr_en) begin
			value <= next_value;
		end
	end

endmodule

// ===== cbl_pkg.sv
// Purpose: Shared constants and types for the channel, bias and lead-off bank
// Assumes: Register indices; byte address on the bus is four times the index
// Notes:   One number, one name; modules import the whole package
package cbl_pkg;

	localparam int NUM_CH = 8;

	// Register indices
	localparam logic [5:0] IDX_CH_FIRST   = 6'h05;
	localparam logic [5:0] IDX_CH_LAST    = 6'h0c;
	localparam logic [5:0] IDX_BIAS_POS   = 6'h0d;
	localparam logic [5:0] IDX_BIAS_NEG   = 6'h0e;
	localparam logic [5:0] IDX_LOFF_POS   = 6'h0f;
	localparam logic [5:0] IDX_LOFF_NEG   = 6'h10;
	localparam logic [5:0] IDX_DETACH_POS = 6'h12;
	localparam logic [5:0] IDX_MEAS_CTRL  = 6'h1f;

	// Reset values
	localparam logic [7:0] CH_SET_RESET    = 8'h61;
	localparam logic [7:0] MASK_RESET      = 8'h00;
	localparam logic [7:0] DETACH_RESET    = 8'h00;
	localparam logic       MEAS_CTRL_RESET = 1'b0;
	localparam logic [2:0] GAIN_RESET      = 3'h6;

	// Field positions in a channel setting byte and in the measurement control byte
	localparam int PD_BIT   = 7;
	localparam int GAIN_LSB = 4;
	localparam int REF_BIT  = 3;
	localparam int SEL_LSB  = 0;
	localparam int MEAS_BIT = 0;

	localparam logic [2:0] GAIN_BAD = 3'h7;

	// Input selector codes
	localparam logic [2:0] SEL_NORMAL    = 3'h0;
	localparam logic [2:0] SEL_SHORTED   = 3'h1;
	localparam logic [2:0] SEL_BIAS_MEASURE_ENABLE = 3'h2;
	localparam logic [2:0] SEL_SUPPLY    = 3'h3;
	localparam logic [2:0] SEL_TEMP      = 3'h4;
	localparam logic [2:0] SEL_TEST      = 3'h5;
	localparam logic [2:0] SEL_DRIVE_POS = 3'h6;
	localparam logic [2:0] SEL_DRIVE_NEG = 3'h7;

	typedef struct packed {
		logic       channel_powerdown;
		logic [2:0] amp_gain_sel;
		logic       shared_ref_switch;
		logic [2:0] input_select;
	} cbl_chan_cfg_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} cbl_apb_req_t;

	function automatic logic cbl_is_chan_idx(input logic [5:0] idx);
		return (idx >= IDX_CH_FIRST) && (idx <= IDX_CH_LAST);
	endfunction

	// Bits for channels that exist on the built variant
	function automatic logic [7:0] cbl_valid_mask(input int channels);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i < channels) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

endpackage

// ===== cbl_regs.sv
// Purpose: APB register bank for channel settings, bias and lead-off masks
// Assumes: APB with one access cycle; byte data in lane 0 of the word
// Notes:   Outputs feed the analog front end; all come from flip-flops
`timescale 1ns/1ps

module cbl_regs
	import cbl_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
)
(
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  cbl_apb_req_t                apb_req,
	output logic          [31:0]        prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic     [7:0]         positive_detach_in,
	output cbl_chan_cfg_t [NUM_CH-1:0]  chan_cfg,
	output logic          [7:0]         bias_positive_route_mask,
	output logic          [7:0]         bias_negative_route_mask,
	output logic          [7:0]         positive_leadoff_enable,
	output logic          [7:0]         negative_leadoff_enable,
	output logic          [7:0]         positive_detach_status,
	output logic                        bias_measure_enable,
	output logic          [7:0]         bias_measure_route,
	output logic          [7:0]         bias_drive_from_positive,
	output logic          [7:0]         bias_drive_from_negative,
	output logic          [7:0]         gain_illegal
);

	localparam logic [7:0] VALID = cbl_valid_mask(CHANNELS);

	// Bus decode
	wire logic [5:0] idx       = apb_req.paddr[7:2];
	wire logic       aligned   = (apb_req.paddr[1:0] == 2'b00);
	wire logic       is_chan   = cbl_is_chan_idx(idx);
	wire logic       is_bpos   = (idx == IDX_BIAS_POS);
	wire logic       is_bneg   = (idx == IDX_BIAS_NEG);
	wire logic       is_lpos   = (idx == IDX_LOFF_POS);
	wire logic       is_lneg   = (idx == IDX_LOFF_NEG);
	wire logic       is_detach = (idx == IDX_DETACH_POS);
	wire logic       is_meas   = (idx == IDX_MEAS_CTRL);
	wire logic       hit       = aligned && (is_chan || is_bpos || is_bneg
		|| is_lpos || is_lneg || is_detach || is_meas);
	wire logic [5:0] ch_off    = idx - IDX_CH_FIRST;

	wire logic setup_phase = apb_req.psel && !apb_req.penable;
	wire logic access_done = apb_req.psel && apb_req.penable && pready;

	// Lane 0 only carries data; a write without it changes nothing
	wire logic wr_fire = access_done && apb_req.pwrite && apb_req.pstrb[0]
		&& !pslverr;
	wire logic [7:0] wdata = apb_req.pwdata[7:0];

	wire logic wr_chan = wr_fire && cbl_is_chan_idx(idx);
	wire logic wr_bpos = wr_fire && is_bpos;
	wire logic wr_bneg = wr_fire && is_bneg;
	wire logic wr_lpos = wr_fire && is_lpos;
	wire logic wr_lneg = wr_fire && is_lneg;
	wire logic wr_meas = wr_fire && is_meas;

	wire logic [7:0] read_chan = chan_cfg[ch_off[2:0]];
	wire logic [7:0] read_byte =
		is_chan   ? read_chan :
		is_bpos   ? bias_positive_route_mask :
		is_bneg   ? bias_negative_route_mask :
		is_lpos   ? positive_leadoff_enable :
		is_lneg   ? negative_leadoff_enable :
		is_detach ? positive_detach_status :
		is_meas   ? {7'h00, bias_measure_enable} :
		8'h00;

	// Answer is fixed up at setup, so every access has zero wait states
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase && !hit;
			if (setup_phase) begin
				prdata <= (hit && !apb_req.pwrite) ?
					{24'h00_0000, read_byte} : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			chan_cfg <= {NUM_CH{CH_SET_RESET}};
		end else if (wr_chan) begin
			chan_cfg[ch_off[2:0]] <= wdata;
		end
	end

	cbl_mask_reg u_bias_pos (
		.clk        (clk),
		.reset_n    (reset_n),
		.wr_en      (wr_bpos),
		.wr_data    (wdata),
		.valid_mask (VALID),
		.value      (bias_positive_route_mask)
	);

	cbl_mask_reg u_bias_neg (
		.clk        (clk),
		.reset_n    (reset_n),
		.wr_en      (wr_bneg),
		.wr_data    (wdata),
		.valid_mask (VALID),
		.value      (bias_negative_route_mask)
	);

	cbl_mask_reg u_loff_pos (
		.clk        (clk),
		.reset_n    (reset_n),
		.wr_en      (wr_lpos),
		.wr_data    (wdata),
		.valid_mask (VALID),
		.value      (positive_leadoff_enable)
	);

	cbl_mask_reg u_loff_neg (
		.clk        (clk),
		.reset_n    (reset_n),
		.wr_en      (wr_lneg),
		.wr_data    (wdata),
		.valid_mask (VALID),
		.value      (negative_leadoff_enable)
	);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bias_measure_enable <= MEAS_CTRL_RESET;
		end else if (wr_meas) begin
			bias_measure_enable <= wdata[MEAS_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			positive_detach_status <= DETACH_RESET;
		end else begin
			positive_detach_status <= positive_detach_in & VALID;
		end
	end

	// Per-channel decode, registered so outputs come from flops
	logic [7:0] dec_illegal;
	logic [7:0] dec_meas;
	logic [7:0] dec_dpos;
	logic [7:0] dec_dneg;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_dec
		cbl_chan_decode u_dec (
			.cfg                 (chan_cfg[g]),
			.bias_measure_enable (bias_measure_enable),
			.gain_illegal        (dec_illegal[g]),
			.measure_route       (dec_meas[g]),
			.drive_from_pos      (dec_dpos[g]),
			.drive_from_neg      (dec_dneg[g])
		);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gain_illegal             <= 8'h00;
			bias_measure_route       <= 8'h00;
			bias_drive_from_positive <= 8'h00;
			bias_drive_from_negative <= 8'h00;
		end else begin
			gain_illegal             <= dec_illegal;
			bias_measure_route       <= dec_meas;
			bias_drive_from_positive <= dec_dpos;
			bias_drive_from_negative <= dec_dneg;
		end
	end

	AST_CH_RESET: assert property (
		@(posedge clk) disable iff (!reset_n)
		$past(!reset_n) |-> (chan_cfg[0] == CH_SET_RESET)
			&& (chan_cfg[NUM_CH-1] == CH_SET_RESET))
		else $error("channel setting not at reset value");

	AST_PD_WRITE: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_fire && idx == IDX_CH_FIRST) |=>
			chan_cfg[0].channel_powerdown == $past(apb_req.pwdata[PD_BIT]))
		else $error("power-down bit did not follow write");

	AST_GAIN_FLAG: assert property (
		@(posedge clk) disable iff (!reset_n)
		(chan_cfg[7].amp_gain_sel == GAIN_BAD) |=> gain_illegal[7])
		else $error("prohibited gain code not flagged");

	AST_GAIN_OK: assert property (
		@(posedge clk) disable iff (!reset_n)
		$past(!reset_n) |-> chan_cfg[5].amp_gain_sel == GAIN_RESET
			##1 !gain_illegal[5])
		else $error("gain reset value wrong or flagged");

	AST_REF_SWITCH: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_fire && idx == IDX_CH_FIRST + 6'h02) |=>
			chan_cfg[2].shared_ref_switch == $past(apb_req.pwdata[REF_BIT]))
		else $error("reference switch bit did not follow write");

	AST_DRIVE_POS: assert property (
		@(posedge clk) disable iff (!reset_n)
		(chan_cfg[6].input_select == SEL_DRIVE_POS) |=>
			bias_drive_from_positive[6] && !bias_drive_from_negative[6])
		else $error("positive drive selector not routed");

	AST_BIAS_POS: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_bpos |=> bias_positive_route_mask
			== ($past(apb_req.pwdata[7:0]) & VALID))
		else $error("positive bias mask did not take write");

	AST_BIAS_NEG: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_bneg |=> bias_negative_route_mask
			== ($past(apb_req.pwdata[7:0]) & VALID))
		else $error("negative bias mask did not take write");

	AST_LOFF_POS: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_lpos |=> positive_leadoff_enable
			== ($past(apb_req.pwdata[7:0]) & VALID))
		else $error("positive lead-off enable did not take write");

	AST_LOFF_NEG: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_lneg |=> negative_leadoff_enable
			== ($past(apb_req.pwdata[7:0]) & VALID))
		else $error("negative lead-off enable did not take write");

	AST_ABSENT_ZERO: assert property (
		@(posedge clk) disable iff (!reset_n)
		((bias_positive_route_mask | bias_negative_route_mask
			| positive_leadoff_enable | negative_leadoff_enable)
			& ~VALID) == 8'h00)
		else $error("bit of absent channel is set");

	AST_MASK_RESET: assert property (
		@(posedge clk) disable iff (!reset_n)
		$past(!reset_n) |-> (bias_positive_route_mask == MASK_RESET)
			&& (negative_leadoff_enable == MASK_RESET))
		else $error("mask register not cleared by reset");

	AST_MEAS_ROUTE: assert property (
		@(posedge clk) disable iff (!reset_n)
		(bias_measure_enable && chan_cfg[2].input_select == SEL_BIAS_MEASURE_ENABLE)
			|=> bias_measure_route[2])
		else $error("bias measurement not routed");

	AST_MEAS_OFF: assert property (
		@(posedge clk) disable iff (!reset_n)
		!bias_measure_enable |=> bias_measure_route == 8'h00)
		else $error("bias measurement routed while disabled");

	AST_DETACH: assert property (
		@(posedge clk) disable iff (!reset_n)
		!$past(!reset_n) |-> positive_detach_status
			== ($past(positive_detach_in) & VALID))
		else $error("detach status does not track input");

	AST_READBACK: assert property (
		@(posedge clk) disable iff (!reset_n)
		(setup_phase && !apb_req.pwrite && aligned && is_lpos)
			|=> prdata[7:0] == $past(positive_leadoff_enable)
			&& prdata[31:8] == 24'h00_0000)
		else $error("read did not return stored mask");

	AST_READY_PULSE: assert property (
		@(posedge clk) disable iff (!reset_n)
		setup_phase |=> pready ##1 !pready)
		else $error("ready not a single access cycle");

	AST_GAIN_STORED: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_fire && idx == IDX_CH_LAST) |=> chan_cfg[NUM_CH-1].amp_gain_sel
			== $past(apb_req.pwdata[GAIN_LSB +: 3]))
		else $error("gain code not stored as written");

	AST_DRIVE_NEG: assert property (
		@(posedge clk) disable iff (!reset_n)
		(chan_cfg[7].input_select == SEL_DRIVE_NEG) |=>
			bias_drive_from_negative[7] && !bias_drive_from_positive[7])
		else $error("negative drive selector not routed");

	AST_STRB_IGNORE: assert property (
		@(posedge clk) disable iff (!reset_n)
		(access_done && apb_req.pwrite && !apb_req.pstrb[0] && is_bpos)
			|=> $stable(bias_positive_route_mask))
		else $error("write without lane 0 changed a mask");

	AST_MEAS_WRITE: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_meas |=> bias_measure_enable == $past(apb_req.pwdata[MEAS_BIT]))
		else $error("measurement enable did not take write");

	AST_MISS_ANSWER: assert property (
		@(posedge clk) disable iff (!reset_n)
		(setup_phase && !hit) |=> pready && pslverr
			&& (prdata == 32'h0000_0000))
		else $error("unmapped access not refused");

	AST_MISS_NO_WRITE: assert property (
		@(posedge clk) disable iff (!reset_n)
		(access_done && apb_req.pwrite && pslverr) |=> $stable(chan_cfg)
			&& $stable(bias_positive_route_mask))
		else $error("refused write changed a register");

	AST_CH_HOLD: assert property (
		@(posedge clk) disable iff (!reset_n)
		!wr_chan |=> $stable(chan_cfg))
		else $error("channel setting changed without a write");

endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for the channel and mask register bank
// Assumes: Six-channel build, so mask bits 7:6 are absent
// Notes:   Expected values come from field positions, never from outputs
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		n_tests++; \
		if ((g) !== (e)) begin \
			fail_count++; \
			$display("[ERR] %s exp %h got %h", nm, e, g); \
		end \
	end
module tb_top
	import cbl_pkg::*;
;
	localparam int CH = 6;
	logic                       clk;
	logic                       reset_n;
	logic          [7:0]        detach_in;
	cbl_apb_req_t               apb_req;
	logic          [31:0]       prdata;
	logic                       pready;
	logic                       pslverr;
	cbl_chan_cfg_t [NUM_CH-1:0] cfg;
	logic          [7:0]        mk [4];
	logic          [7:0]        dstat, mroute, dpos, dneg, gbad;
	logic                       meas_en;
	logic          [7:0]        v;
	int                         fail_count, n_tests;

	cbl_regs #(.CHANNELS(CH)) i_dut (
		.clk                      (clk),
		.reset_n                  (reset_n),
		.apb_req                  (apb_req),
		.prdata                   (prdata),
		.pready                   (pready),
		.pslverr                  (pslverr),
		.positive_detach_in       (detach_in),
		.chan_cfg                 (cfg),
		.bias_positive_route_mask (mk[0]),
		.bias_negative_route_mask (mk[1]),
		.positive_leadoff_enable  (mk[2]),
		.negative_leadoff_enable  (mk[3]),
		.positive_detach_status   (dstat),
		.bias_measure_enable      (meas_en),
		.bias_measure_route       (mroute),
		.bias_drive_from_positive (dpos),
		.bias_drive_from_negative (dneg),
		.gain_illegal             (gbad)
	);

	cbl_host_model i_host (
		.clk     (clk),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.apb_req (apb_req)
	);

	initial begin
		clk = 1'b0;
	end
	always #12.5 clk = ~clk;

	function automatic logic [7:0] ba(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction

	// Each channel gets its own selector code; channel 7 the bad gain
	function automatic logic [7:0] chv(input int g);
		logic [2:0] s;
		s = 3'(g);
		return {s[0], (g == 7) ? GAIN_BAD : s, s[1], s};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic xf(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [3:0] s,
		input logic [7:0] e, input logic ee);
		logic [31:0] r;
		logic        er, h;
		i_host.xfer(w, a, d, s, r, er, h);
		if (h) begin
			fail_count++;
			wrap_up();
		end else begin
			if (!w) begin
				`CHK("prdata", {24'h0, e}, r)
			end
			`CHK("pslverr", ee, er)
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		reset_n = 1'b0;
		detach_in = 8'h00;
		fail_count = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		for (int g = 0; g < 8; g++) begin
			xf(0, ba(IDX_CH_FIRST + 6'(g)), 0, 0, 8'h61, 0);
			`CHK("cfg", 8'h61, cfg[g])
		end
		for (int k = 0; k < 4; k++) begin
			xf(0, ba(IDX_BIAS_POS + 6'(k)), 0, 0, 8'h00, 0);
			`CHK("mask", 8'h00, mk[k])
		end
		for (int g = 0; g < 8; g++) begin
			xf(1, ba(IDX_CH_FIRST + 6'(g)), chv(g), 4'hf, 0, 0);
		end
		settle(2);
		for (int g = 0; g < 8; g++) begin
			v = chv(g);
			xf(0, ba(IDX_CH_FIRST + 6'(g)), 0, 0, v, 0);
			`CHK("pd", v[7], cfg[g].channel_powerdown)
			`CHK("gain", v[6:4], cfg[g].amp_gain_sel)
			`CHK("ref", v[3], cfg[g].shared_ref_switch)
			`CHK("sel", v[2:0], cfg[g].input_select)
		end
		`CHK("gbad", 8'h80, gbad)
		`CHK("dpos", 8'h40, dpos)
		`CHK("dneg", 8'h80, dneg)
		`CHK("mroute", 8'h00, mroute)
		xf(1, ba(IDX_MEAS_CTRL), 8'h01, 4'hf, 0, 0);
		settle(2);
		`CHK("meas", 1'b1, meas_en)
		`CHK("mroute", 8'h04, mroute)
		// Host keeps absent mask bits at zero here
		for (int k = 0; k < 4; k++) begin
			v = 8'h3f ^ (8'h01 << k);
			xf(1, ba(IDX_BIAS_POS + 6'(k)), v, 4'hf, 0, 0);
			xf(0, ba(IDX_BIAS_POS + 6'(k)), 0, 0, v, 0);
			`CHK("mask", v, mk[k])
		end
		xf(1, ba(IDX_LOFF_POS), 8'hff, 4'hf, 0, 0);
		xf(0, ba(IDX_LOFF_POS), 0, 0, 8'h3f, 0);
		xf(1, ba(IDX_BIAS_POS), 8'h00, 4'he, 0, 0);
		xf(0, ba(IDX_BIAS_POS), 0, 0, 8'h3e, 0);
		xf(0, ba(6'h11), 0, 0, 8'h00, 1);
		xf(1, ba(6'h11), 8'h55, 4'hf, 0, 1);
		xf(0, 8'h15, 0, 0, 8'h00, 1);
		@(posedge clk);
		detach_in <= 8'hda;
		settle(2);
		`CHK("dstat", 8'h1a, dstat)
		xf(1, ba(IDX_DETACH_POS), 8'h00, 4'hf, 0, 0);
		// Status is read-only; the write above leaves it at the input masked to present channels
		xf(0, ba(IDX_DETACH_POS), 0, 0, 8'h1a, 0);
		xf(1, ba(IDX_CH_FIRST), 8'he1, 4'hf, 0, 0);
		settle(1);
		`CHK("cfg", 8'he1, cfg[0])
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		`CHK("cfg", 8'h61, cfg[0])
		`CHK("mask", 8'h00, mk[2])
		xf(0, ba(IDX_LOFF_NEG), 0, 0, 8'h00, 0);
		wrap_up();
	end
endmodule
